// [rtl/scd_pkg.sv]
package scd_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_RUN_CFG = 8'h00;
  localparam logic [7:0] OFS_RUN_CFG_EXT = 8'h04;
  localparam logic [7:0] OFS_DSLP_CFG = 8'h08;
  localparam logic [7:0] OFS_GATE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Field positions, base, extended and deep sleep registers
  localparam int POS_MOSC_DIS = 0;
  localparam int POS_IOSC_DIS = 1;
  localparam int POS_OSC_LO = 4;
  localparam int POS_CRYSTAL_VALUE_FIELD_LO = 6;
  localparam int POS_PLL_SKIP = 11;
  localparam int POS_PLL_PWD = 13;
  localparam int POS_DIV_APPLY = 22;
  localparam int POS_DIV_LO = 23;
  localparam int POS_EXT_SEL = 31;
  localparam int POS_DSLP_EN = 0;
  localparam int DIV_W = 4;
  localparam int DIV_WIDE_W = DIV_W + 2;
  localparam int CRYSTAL_VALUE_FIELD_W = 5;
  // Reset values
  localparam logic [31:0] RUN_CFG_RST = 32'h0780_3A50;
  localparam logic [31:0] RUN_CFG_EXT_RST = 32'h07C0_2810;
  localparam logic [31:0] DSLP_CFG_RST = 32'h0780_0000;
  localparam logic [31:0] GATE_RST = 32'h0000_0000;
  // Oscillator sources
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_INT = 3'h1;
  localparam logic [2:0] SRC_INT_DIV4 = 3'h2;
  localparam logic [2:0] SRC_LOW = 3'h3;
  localparam logic [2:0] SRC_RTC = 3'h7;
  localparam logic [1:0] INT_DIV4_LAST = 2'h3;
  // Divider figures
  localparam logic [6:0] PLL_MIN_ENC = 7'h03;
  localparam logic [6:0] PLL_MIN_DIVISOR = 7'h04;
  localparam logic [6:0] BYP_MIN_DIVISOR = 7'h02;
  localparam logic [6:0] UNDIVIDED = 7'h01;
  // PLL lock counts in main oscillator cycles
  localparam int LOCK_COUNT_LOW = 'h1200;
  localparam int LOCK_COUNT_HIGH = 'h2400;
  localparam logic [CRYSTAL_VALUE_FIELD_W-1:0] CRYSTAL_VALUE_FIELD_HIGH_LIMIT = 5'h0F;
  localparam int LOCK_W = 14;
  // Converter clock: fractional step from the halved VCO
  localparam int VCO_HALF_MHZ = 200;
  localparam int ADC_MHZ = 16;
  localparam logic [7:0] ADC_STEP = 8'(ADC_MHZ);
  localparam logic [7:0] ADC_WRAP = 8'(VCO_HALF_MHZ);
  localparam int CLK_MHZ = 50;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scd_bus_req_type;

  typedef struct packed {
    logic usePll;
    logic [2:0] src;
    logic [6:0] divisor;
  } scd_clk_cfg_type;
endpackage : scd_pkg

// [rtl/scd_clock_divider.sv]
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Extended register fields win over base fields when extended config is used.
// - Override only while ext_config_select is set; otherwise base fields rule.
// - Divider acts on PLL when pll_skip clear, on oscillator when set.
// - PLL path uses VCO divided by two before the divisor.
// - Effective divisor is the encoding plus one, base and wide fields.
// - PLL encodings below 0x3 reserved; 0x3 gives 50 MHz, default 0xF 12.5.
// - Bypass path divides source by divisor; encodings 0x0 and 0x1 divide by two.
// - Wide divider field is two bits wider, up to 0x3F for /64.
// - With extended config, pll_skip_ext chooses PLL or oscillator.
// - divider_apply clear and no PLL gives undivided source clock.
// - Converter clock derived at 16 MHz, independent of system divider.
// - Each peripheral has its own software-controlled gate off the system clock.
// - In deep sleep, source and divider may come from deep_sleep_clock_config.
// - Registers enable/disable oscillators and PLL and select crystal value.
// - Registers select the clock source used in deep sleep.
// - Source select: 0x0 main, 0x1 internal, 0x2 internal/4, 0x3 low-frequency.
// - PLL not used as system clock until lock counter expires.
module scd_clock_divider
  import scd_pkg::*;
#(
  parameter int N_PERIPH = 8,
  parameter int LOCK_LOW = LOCK_COUNT_LOW,
  parameter int LOCK_HIGH = LOCK_COUNT_HIGH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Register port
  input wire scd_bus_req_type busReq,
  output logic [31:0] rdata,
  // Oscillator pins: main, internal, low-frequency, real-time
  input wire logic [3:0] oscPin,
  // Halved VCO tick from the PLL, same clock domain
  input wire logic pllHalfTick,
  input wire logic deepSleep,
  // Clock tree enables and oscillator controls
  output logic sysClkEn,
  output logic adcClkEn,
  output logic [N_PERIPH-1:0] periphClkEn,
  output logic mainOscEnable,
  output logic intOscEnable,
  output logic pllPowerUp,
  output logic [CRYSTAL_VALUE_FIELD_W-1:0] crystalValue,
  output logic pllLocked
);

  function automatic logic [6:0] calcDivisor(input logic [6:0] enc, input logic usePll,
                                             input logic apply);
    logic [6:0] d;
    d = 7'(enc + 7'h01);
    if (usePll) begin
      calcDivisor = (enc < PLL_MIN_ENC) ? PLL_MIN_DIVISOR : d;
    end else if (!apply) begin
      calcDivisor = UNDIVIDED;
    end else begin
      calcDivisor = (d < BYP_MIN_DIVISOR) ? BYP_MIN_DIVISOR : d;
    end
  endfunction : calcDivisor

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] runCfg_reg;
  logic [31:0] runCfgExt_reg;
  logic [31:0] dslpCfg_reg;
  logic [N_PERIPH-1:0] gate_reg;
  logic [31:0] status;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runCfg_reg <= RUN_CFG_RST;
      runCfgExt_reg <= RUN_CFG_EXT_RST;
      dslpCfg_reg <= DSLP_CFG_RST;
      gate_reg <= N_PERIPH'(GATE_RST);
    end else if (ce && busReq.wr) begin
      case (busReq.addr)
        OFS_RUN_CFG: runCfg_reg <= busReq.wdata;
        OFS_RUN_CFG_EXT: runCfgExt_reg <= busReq.wdata;
        OFS_DSLP_CFG: dslpCfg_reg <= busReq.wdata;
        OFS_GATE: gate_reg <= busReq.wdata[N_PERIPH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (ce) begin
      if (busReq.rd) begin
        case (busReq.addr)
          OFS_RUN_CFG: rdata <= runCfg_reg;
          OFS_RUN_CFG_EXT: rdata <= runCfgExt_reg;
          OFS_DSLP_CFG: rdata <= dslpCfg_reg;
          OFS_GATE: rdata <= 32'(gate_reg);
          OFS_STATUS: rdata <= status;
          default: rdata <= '0;
        endcase
      end else begin
        rdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic extSel;
  logic pllPwd;
  logic [CRYSTAL_VALUE_FIELD_W-1:0] crystal_value_field;
  assign extSel = runCfgExt_reg[POS_EXT_SEL];
  assign pllPwd = extSel ? runCfgExt_reg[POS_PLL_PWD] : runCfg_reg[POS_PLL_PWD];
  assign crystal_value_field = runCfg_reg[POS_CRYSTAL_VALUE_FIELD_LO +: CRYSTAL_VALUE_FIELD_W];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mainOscEnable <= 1'b0;
      intOscEnable <= 1'b1;
      pllPowerUp <= 1'b0;
      crystalValue <= '0;
    end else if (ce) begin
      mainOscEnable <= !runCfg_reg[POS_MOSC_DIS];
      intOscEnable <= !runCfg_reg[POS_IOSC_DIS];
      pllPowerUp <= !pllPwd;
      crystalValue <= crystal_value_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator pin synchronisers
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] oscLevel_reg;
  logic [3:0] oscTick;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          oscLevel_reg[gi] <= 1'b0;
        end else if (ce) begin
          sync1_reg[gi] <= oscPin[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            oscLevel_reg[gi] <= sync2_reg[gi];
          end
        end
      end
      assign oscTick[gi] = (sync2_reg[gi] == sync3_reg[gi]) && sync2_reg[gi] &&
                           !oscLevel_reg[gi];
    end
  endgenerate

  logic [1:0] intDiv_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intDiv_reg <= '0;
    end else if (ce && oscTick[1]) begin
      intDiv_reg <= 2'(intDiv_reg + 2'h1);
    end
  end

  // Disabled main and internal oscillators deliver no ticks; the internal/4 source counts raw internal ticks
  logic mainTick;
  logic intTick;
  assign mainTick = oscTick[0] && !runCfg_reg[POS_MOSC_DIS];
  assign intTick = oscTick[1] && !runCfg_reg[POS_IOSC_DIS];

  function automatic logic srcTick(input logic [2:0] sel, input logic mainT, input logic intT,
                                   input logic div4T, input logic lowT, input logic rtcT);
    case (sel)
      SRC_MAIN: srcTick = mainT;
      SRC_INT: srcTick = intT;
      SRC_INT_DIV4: srcTick = div4T;
      SRC_LOW: srcTick = lowT;
      SRC_RTC: srcTick = rtcT;
      default: srcTick = 1'b0;
    endcase
  endfunction : srcTick

  ////////////////////////////////////////////////////////////////////////////////
  // PLL lock timer
  logic [LOCK_W-1:0] lockCnt_reg;
  logic [CRYSTAL_VALUE_FIELD_W-1:0] xtalPrev_reg;
  logic pllPwdPrev_reg;
  logic relock;
  logic pllReady;
  assign relock = (crystal_value_field != xtalPrev_reg) || (pllPwdPrev_reg && !pllPwd);
  // A relock request blocks ready in its own cycle, before the counter has reloaded
  assign pllReady = (lockCnt_reg == '0) && !pllPwd && !relock;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockCnt_reg <= '0;
      xtalPrev_reg <= RUN_CFG_RST[POS_CRYSTAL_VALUE_FIELD_LO +: CRYSTAL_VALUE_FIELD_W];
      pllPwdPrev_reg <= 1'b1;
    end else if (ce) begin
      xtalPrev_reg <= crystal_value_field;
      pllPwdPrev_reg <= pllPwd;
      if (relock) begin
        lockCnt_reg <= (crystal_value_field > CRYSTAL_VALUE_FIELD_HIGH_LIMIT) ? LOCK_W'(LOCK_HIGH) : LOCK_W'(LOCK_LOW);
      end else if (mainTick && lockCnt_reg != '0) begin
        lockCnt_reg <= LOCK_W'(lockCnt_reg - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pllLocked <= 1'b0;
    end else if (ce) begin
      pllLocked <= pllReady;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration selection
  scd_clk_cfg_type cfgNext;
  logic wantPll;
  logic [6:0] encSel;

  always_comb begin
    cfgNext = '0;
    wantPll = 1'b0;
    encSel = '0;
    if (deepSleep && dslpCfg_reg[POS_DSLP_EN]) begin
      encSel = 7'(dslpCfg_reg[POS_DIV_LO +: DIV_WIDE_W]);
      cfgNext.src = dslpCfg_reg[POS_OSC_LO +: 3];
      cfgNext.divisor = calcDivisor(encSel, 1'b0, 1'b1);
    end else if (extSel) begin
      wantPll = !runCfgExt_reg[POS_PLL_SKIP];
      encSel = 7'(runCfgExt_reg[POS_DIV_LO +: DIV_WIDE_W]);
      cfgNext.src = runCfgExt_reg[POS_OSC_LO +: 3];
      cfgNext.divisor = calcDivisor(encSel, wantPll, 1'b1);
    end else begin
      wantPll = !runCfg_reg[POS_PLL_SKIP];
      encSel = 7'(runCfg_reg[POS_DIV_LO +: DIV_W]);
      cfgNext.src = {1'b0, runCfg_reg[POS_OSC_LO +: 2]};
      cfgNext.divisor = calcDivisor(encSel, wantPll, runCfg_reg[POS_DIV_APPLY]);
    end
    // Until lock the oscillator keeps running the system, undivided rules aside
    cfgNext.usePll = wantPll && pllReady;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System divider: new settings load only at a period boundary
  scd_clk_cfg_type active_reg;
  logic [6:0] divCnt_reg;
  logic tick;
  logic wrap;
  assign tick = active_reg.usePll ? pllHalfTick :
                srcTick(active_reg.src, mainTick, intTick,
                        oscTick[1] && intDiv_reg == INT_DIV4_LAST, oscTick[2], oscTick[3]);
  assign wrap = tick && (divCnt_reg >= 7'(active_reg.divisor - 7'h01));

  // A stopped source stalls the switch; software must start a source before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_reg <= '{usePll: 1'b0, src: SRC_MAIN, divisor: UNDIVIDED};
      divCnt_reg <= '0;
      sysClkEn <= 1'b0;
    end else if (ce) begin
      sysClkEn <= wrap;
      if (wrap) begin
        divCnt_reg <= '0;
        active_reg <= cfgNext;
      end else if (tick) begin
        divCnt_reg <= 7'(divCnt_reg + 7'h01);
      end
    end
  end

  generate
    for (gi = 0; gi < N_PERIPH; gi++) begin : g_gate
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          periphClkEn[gi] <= 1'b0;
        end else if (ce) begin
          periphClkEn[gi] <= wrap && gate_reg[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock: 16 of every 200 halved VCO ticks, spread evenly
  logic [7:0] adcAcc_reg;
  logic [8:0] adcSum;
  assign adcSum = {1'b0, adcAcc_reg} + {1'b0, ADC_STEP};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adcAcc_reg <= '0;
      adcClkEn <= 1'b0;
    end else if (ce) begin
      adcClkEn <= 1'b0;
      if (pllHalfTick && !pllPwd) begin
        if (adcSum >= {1'b0, ADC_WRAP}) begin
          adcAcc_reg <= 8'(adcSum - {1'b0, ADC_WRAP});
          adcClkEn <= 1'b1;
        end else begin
          adcAcc_reg <= adcSum[7:0];
        end
      end
    end
  end

  assign status = {pllReady, active_reg.usePll, 15'h0000, active_reg.src, 5'h00,
                   active_reg.divisor};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence relockSeq;
    ce && pllPwdPrev_reg && !pllPwd;
  endsequence

  sequence loadSeq;
    ce && wrap;
  endsequence

  pll_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    relockSeq |=> !pllReady [*2])
    else $error("PLL ready right after power-up");
  pll_use_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(active_reg.usePll) |-> $past(pllReady))
    else $error("PLL used before lock");
  switch_clean_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(active_reg) |-> sysClkEn)
    else $error("Config changed mid-period");
  load_next_a: assert property (@(posedge clk) disable iff (!reset_n)
    loadSeq |=> active_reg == $past(cfgNext))
    else $error("Config not loaded at boundary");
  pll_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfgNext.usePll |-> cfgNext.divisor >= PLL_MIN_DIVISOR)
    else $error("Reserved PLL divisor used");
  undivided_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!deepSleep && !extSel && !wantPll && !runCfg_reg[POS_DIV_APPLY])
      |-> cfgNext.divisor == UNDIVIDED)
    else $error("Undivided source not selected");
  bypass_two_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!deepSleep && !extSel && !wantPll && runCfg_reg[POS_DIV_APPLY] &&
     runCfg_reg[POS_DIV_LO +: DIV_W] == 4'h0) |-> cfgNext.divisor == BYP_MIN_DIVISOR)
    else $error("Bypass encoding zero not halved");
  ext_skip_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!deepSleep && extSel) |-> wantPll == !runCfgExt_reg[POS_PLL_SKIP])
    else $error("Extended skip bit ignored");
  wide_max_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!deepSleep && extSel && runCfgExt_reg[POS_DIV_LO +: DIV_WIDE_W] == 6'h3F)
      |-> cfgNext.divisor == 7'h40)
    else $error("Wide divider not /64");
  gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    periphClkEn[0] |-> sysClkEn && $past(gate_reg[0]))
    else $error("Peripheral clock leaked through gate");
  adc_src_a: assert property (@(posedge clk) disable iff (!reset_n)
    (adcClkEn && $past(ce)) |-> $past(pllHalfTick))
    else $error("Converter tick without source");

endmodule : scd_clock_divider
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import scd_pkg::*;
  logic clk, reset_n, ce, pllHalfTick, deepSleep;
  scd_bus_req_type busReq;
  logic [31:0] rdata, d, g, r;
  logic [3:0] oscPin;
  logic sysClkEn, adcClkEn, mainOscEnable, intOscEnable, pllPowerUp, pllLocked;
  logic [7:0] periphClkEn;
  logic [CRYSTAL_VALUE_FIELD_W-1:0] crystalValue;
  int num_errors, checked, cycles, oscCnt, iv, n;
  integer seed;

  // Lock counts shortened so the PLL lock wait below stays short
  scd_clock_divider #(.N_PERIPH(8), .LOCK_LOW(40), .LOCK_HIGH(80)) DUT (
    .clk(clk), .reset_n(reset_n), .ce(ce), .busReq(busReq), .rdata(rdata),
    .oscPin(oscPin), .pllHalfTick(pllHalfTick), .deepSleep(deepSleep),
    .sysClkEn(sysClkEn), .adcClkEn(adcClkEn), .periphClkEn(periphClkEn),
    .mainOscEnable(mainOscEnable), .intOscEnable(intOscEnable), .pllPowerUp(pllPowerUp),
    .crystalValue(crystalValue), .pllLocked(pllLocked));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Distinct source periods (main 6, internal 4, low 10, real-time 8) so a wrong pick shows
  always @(posedge clk) begin
    oscCnt <= oscCnt + 1;
    oscPin <= {oscCnt % 8 < 4, oscCnt % 10 < 5, oscCnt % 4 < 2, oscCnt % 6 < 3};
    pllHalfTick <= (oscCnt % 2 == 0);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd

  // Cycles to the next system tick, bounded so a dead divider cannot hang the run
  task automatic pulse;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sysClkEn !== 1'b1 && n < 2000);
    if (n >= 2000) chk("sysClkEn pulse", 1, 0);
  endtask : pulse

  // New settings only land on a period boundary, so let three periods pass first
  task automatic interval(output int c);
    pulse();
    pulse();
    pulse();
    pulse();
    c = n;
  endtask : interval

  function automatic logic [31:0] bw(input int src, skip, pwd, apply, dv);
    bw = 32'h0000_0000;
    bw[POS_OSC_LO +: 2] = 2'(src);
    bw[POS_CRYSTAL_VALUE_FIELD_LO +: CRYSTAL_VALUE_FIELD_W] = 5'h09;
    bw[POS_PLL_SKIP] = 1'(skip);
    bw[POS_PLL_PWD] = 1'(pwd);
    bw[POS_DIV_APPLY] = 1'(apply);
    bw[POS_DIV_LO +: DIV_W] = 4'(dv);
  endfunction : bw

  function automatic logic [31:0] ew(input int sel, src, skip, pwd, dv);
    ew = 32'h0000_0000;
    ew[POS_OSC_LO +: 3] = 3'(src);
    ew[POS_PLL_SKIP] = 1'(skip);
    ew[POS_PLL_PWD] = 1'(pwd);
    ew[POS_DIV_LO +: DIV_WIDE_W] = 6'(dv);
    ew[POS_EXT_SEL] = 1'(sel);
  endfunction : ew

  function automatic int per(input int src);
    case (src)
      0: per = 6;
      1: per = 4;
      2: per = 16;
      3: per = 10;
      default: per = 8;
    endcase
  endfunction : per

  function automatic int bdiv(input int enc);
    bdiv = (enc < 2) ? 2 : enc + 1;
  endfunction : bdiv

  task automatic run(input logic [31:0] b, e, input int p, dv, input logic pll);
    wr(OFS_RUN_CFG_EXT, e);
    wr(OFS_RUN_CFG, b);
    interval(iv);
    chk("sysClkEn interval", p * dv, iv);
    rd(OFS_STATUS, d);
    chk("active divisor", dv, {25'h0, d[6:0]});
    chk("pll in use", {31'h0, pll}, {31'h0, d[30]});
    $display("case done: interval %0d", iv);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hdd37_5dba;
    {ce, deepSleep, reset_n} = 3'b100;
    busReq = '0;
    oscPin = 4'h0;
    pllHalfTick = 1'b0;
    {oscCnt, cycles, num_errors, checked} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFS_RUN_CFG, d); chk("base reset", RUN_CFG_RST, d);
    rd(OFS_RUN_CFG_EXT, d); chk("ext reset", RUN_CFG_EXT_RST, d);
    rd(OFS_DSLP_CFG, d); chk("deep sleep reset", DSLP_CFG_RST, d);
    rd(OFS_GATE, d); chk("gate reset", GATE_RST, d);
    rd(8'h14, d); chk("unmapped read", 0, d);
    chk("crystal value", 9, 32'(crystalValue));
    chk("osc enables", 3, {30'h0, mainOscEnable, intOscEnable});
    chk("pll power", 0, {31'h0, pllPowerUp});
    interval(iv); chk("reset interval", 4, iv);
    rd(OFS_STATUS, d); chk("reset divisor", 1, {25'h0, d[6:0]});
    $display("reset test done");
    // Bypass path, base and extended registers
    run(bw(1, 1, 1, 1, 0), ew(0, 3, 1, 1, 5), 4, 2, 1'b0);
    run(bw(1, 1, 1, 1, 1), ew(0, 3, 1, 1, 5), 4, 2, 1'b0);
    run(bw(1, 1, 1, 0, 9), ew(0, 3, 1, 1, 5), 4, 1, 1'b0);
    for (int s = 0; s < 4; s++) run(bw(s, 1, 1, 1, 1), ew(0, 3, 1, 1, 5), per(s), 2, 1'b0);
    run(bw(1, 1, 1, 1, 2), ew(1, 1, 1, 1, 63), 4, 64, 1'b0);
    run(bw(1, 1, 1, 1, 2), ew(0, 3, 1, 1, 5), 4, 3, 1'b0);
    run(bw(1, 1, 1, 1, 2), ew(1, 7, 1, 1, 3), 8, 4, 1'b0);
    repeat (6) begin
      r = $random(seed);
      run(bw(r[1:0], 1, 1, 1, r[5:2]), ew(0, 3, 1, 1, 5), per(r[1:0]), bdiv(r[5:2]), 1'b0);
    end
    run(bw(0, 1, 1, 1, 3), ew(0, 3, 1, 1, 5), 6, 4, 1'b0);
    // PLL path: stays on the oscillator until the lock count runs out
    wr(OFS_RUN_CFG, bw(0, 0, 0, 1, 4));
    interval(iv);
    chk("pll locked early", 0, {31'h0, pllLocked});
    chk("pre-lock interval", 30, iv);
    rd(OFS_STATUS, d); chk("pll used early", 0, {31'h0, d[30]});
    chk("pll power", 1, {31'h0, pllPowerUp});
    n = 0;
    while (pllLocked !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("pll locked", 1, {31'h0, pllLocked});
    run(bw(0, 0, 0, 1, 3), ew(0, 3, 1, 1, 5), 2, 4, 1'b1);
    run(bw(0, 0, 0, 1, 1), ew(0, 3, 1, 1, 5), 2, 4, 1'b1);
    run(bw(0, 0, 0, 1, 15), ew(0, 3, 1, 1, 5), 2, 16, 1'b1);
    run(bw(0, 1, 0, 1, 3), ew(1, 1, 0, 0, 63), 2, 64, 1'b1);
    run(bw(0, 0, 0, 1, 3), ew(1, 1, 1, 0, 5), 4, 6, 1'b0);
    n = 0;
    repeat (1000) begin
      @(negedge clk);
      if (adcClkEn === 1'b1) n++;
    end
    chk("adc tick count", 1, {31'h0, n >= 39 && n <= 41});
    $display("pll test done");
    wr(OFS_DSLP_CFG, 32'h0380_0011);
    deepSleep <= 1'b1;
    interval(iv); chk("deep sleep interval", 32, iv);
    @(posedge clk);
    deepSleep <= 1'b0;
    g = $random(seed) & 32'h0000_00FF;
    wr(OFS_GATE, g);
    rd(OFS_GATE, d); chk("gate readback", g, d);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (periphClkEn !== (sysClkEn ? g[7:0] : 8'h00)) n++;
    end
    chk("gated pulses", 0, n);
    // Freeze right after a tick so the held output is low
    pulse();
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_GATE, 32'h0000_00FF);
    n = 0;
    repeat (60) begin
      @(negedge clk);
      if (sysClkEn !== 1'b0) n++;
    end
    @(posedge clk);
    ce <= 1'b1;
    rd(OFS_GATE, d); chk("frozen write", g, d);
    chk("frozen pulses", 0, n);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFS_RUN_CFG_EXT, d); chk("ext after reset", RUN_CFG_EXT_RST, d);
    wr(OFS_RUN_CFG, 32'h0000_0003);
    @(posedge clk);
    @(negedge clk);
    chk("osc disabled", 0, {30'h0, mainOscEnable, intOscEnable});
    chk("crystal cleared", 0, 32'(crystalValue));
    chk("pll powered", 1, {31'h0, pllPowerUp});
    $display("misc test done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
